/* rtl/tmb_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tmb_map.svh"

module tmb_timer (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // Special function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // Clock selects held in the clock control register
  input  wire logic       high_byte_fast_clock_select,
  input  wire logic       low_byte_fast_clock_select,
  // External oscillator
  input  wire logic       ext_clk,
  // Interrupt
  input  wire logic       timer_irq_enable,
  output logic            irq_request
);

  tmb_tick_if ticks ();

  tmb_tick_gen #(
    .CORE_DIV (`TMB_CORE_DIV),
    .EXT_DIV  (`TMB_EXT_DIV)
  ) u_tick_gen (
    .mclk    (mclk),
    .reset   (reset),
    .ext_clk (ext_clk),
    .ticks   (ticks)
  );

  tmb_pkg::tmb_byte_t ctrl_reg,   ctrl_next;
  tmb_pkg::tmb_byte_t rld_lo_reg, rld_lo_next;
  tmb_pkg::tmb_byte_t rld_hi_reg, rld_hi_next;
  tmb_pkg::tmb_byte_t cnt_lo_reg, cnt_lo_next;
  tmb_pkg::tmb_byte_t cnt_hi_reg, cnt_hi_next;
  tmb_pkg::tmb_byte_t rdata_reg,  rdata_next;
  logic               irq_reg,    irq_next;

  tmb_pkg::tmb_mode_e mode;
  logic               wr_ctrl, wr_rld_lo, wr_rld_hi, wr_cnt_lo, wr_cnt_hi;
  logic               alt_tick, tick_lo, tick_hi;
  logic               run, lo_set, hi_set;
  logic [15:0]        cnt16;

  // Register decode
  always_comb begin
    wr_ctrl   = sfr_wr && (sfr_addr == `TMB_ADDR_CTRL);
    wr_rld_lo = sfr_wr && (sfr_addr == `TMB_ADDR_RLD_LO);
    wr_rld_hi = sfr_wr && (sfr_addr == `TMB_ADDR_RLD_HI);
    wr_cnt_lo = sfr_wr && (sfr_addr == `TMB_ADDR_CNT_LO);
    wr_cnt_hi = sfr_wr && (sfr_addr == `TMB_ADDR_CNT_HI);
  end

  // Count pulse per byte
  always_comb begin
    alt_tick = ctrl_reg[`TMB_BIT_ALT_CLK] ? ticks.ext_tick : ticks.core_tick;
    tick_hi  = high_byte_fast_clock_select | alt_tick;
    tick_lo  = low_byte_fast_clock_select | alt_tick;
    run      = ctrl_reg[`TMB_BIT_RUN];
    mode     = ctrl_reg[`TMB_BIT_SPLIT] ? tmb_pkg::TMB_MODE_SPLIT : tmb_pkg::TMB_MODE_WIDE;
    cnt16    = {cnt_hi_reg, cnt_lo_reg};
  end

  // Counting, reload and overflow detection
  always_comb begin
    cnt_lo_next = cnt_lo_reg;
    cnt_hi_next = cnt_hi_reg;
    lo_set      = 1'b0;
    hi_set      = 1'b0;
    unique case (mode)
      tmb_pkg::TMB_MODE_WIDE: begin
        // Whole word follows the low byte's clock choice
        if (run && tick_lo) begin
          lo_set = (cnt_lo_reg == '1);
          if (cnt16 == '1) begin
            {cnt_hi_next, cnt_lo_next} = {rld_hi_reg, rld_lo_reg};
            hi_set = 1'b1;
          end else begin
            {cnt_hi_next, cnt_lo_next} = cnt16 + 16'h0001;
          end
        end
      end
      tmb_pkg::TMB_MODE_SPLIT: begin
        if (tick_lo) begin
          if (cnt_lo_reg == '1) begin
            cnt_lo_next = rld_lo_reg;
            lo_set      = 1'b1;
          end else begin
            cnt_lo_next = cnt_lo_reg + 8'h01;
          end
        end
        if (run && tick_hi) begin
          if (cnt_hi_reg == '1) begin
            cnt_hi_next = rld_hi_reg;
            hi_set      = 1'b1;
          end else begin
            cnt_hi_next = cnt_hi_reg + 8'h01;
          end
        end
      end
    endcase
    // Software write to a counter byte beats the count in that cycle
    if (wr_cnt_lo) begin
      cnt_lo_next = sfr_wdata;
    end
    if (wr_cnt_hi) begin
      cnt_hi_next = sfr_wdata;
    end
  end

  // Control, reload and flags; a set beats a software clear
  always_comb begin
    ctrl_next = wr_ctrl ? (sfr_wdata & `TMB_CTRL_WR_MASK) : ctrl_reg;
    ctrl_next[`TMB_BIT_HI_OVF] = ctrl_next[`TMB_BIT_HI_OVF] | hi_set;
    ctrl_next[`TMB_BIT_LO_OVF] = ctrl_next[`TMB_BIT_LO_OVF] | lo_set;
    rld_lo_next = wr_rld_lo ? sfr_wdata : rld_lo_reg;
    rld_hi_next = wr_rld_hi ? sfr_wdata : rld_hi_reg;
  end

  // Interrupt request from the stored flags, lagging them by one cycle
  always_comb begin
    irq_next = timer_irq_enable & (ctrl_reg[`TMB_BIT_HI_OVF] |
               (ctrl_reg[`TMB_BIT_LO_IRQ_EN] & ctrl_reg[`TMB_BIT_LO_OVF]));
  end

  // Read data, valid the edge after the read strobe
  always_comb begin
    rdata_next = rdata_reg;
    if (sfr_rd) begin
      unique case (sfr_addr)
        `TMB_ADDR_CTRL:   rdata_next = ctrl_reg;
        `TMB_ADDR_RLD_LO: rdata_next = rld_lo_reg;
        `TMB_ADDR_RLD_HI: rdata_next = rld_hi_reg;
        `TMB_ADDR_CNT_LO: rdata_next = cnt_lo_reg;
        `TMB_ADDR_CNT_HI: rdata_next = cnt_hi_reg;
        default:          rdata_next = `TMB_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrl_reg   <= `TMB_RST_BYTE;
      rld_lo_reg <= `TMB_RST_BYTE;
      rld_hi_reg <= `TMB_RST_BYTE;
      cnt_lo_reg <= `TMB_RST_BYTE;
      cnt_hi_reg <= `TMB_RST_BYTE;
      rdata_reg  <= `TMB_RST_BYTE;
      irq_reg    <= 1'b0;
    end else begin
      ctrl_reg   <= ctrl_next;
      rld_lo_reg <= rld_lo_next;
      rld_hi_reg <= rld_hi_next;
      cnt_lo_reg <= cnt_lo_next;
      cnt_hi_reg <= cnt_hi_next;
      rdata_reg  <= rdata_next;
      irq_reg    <= irq_next;
    end
  end

  assign sfr_rdata   = rdata_reg;
  assign irq_request = irq_reg;

  AST_WIDE_RELOAD: assert property (@(posedge mclk) disable iff (reset)
    (!ctrl_reg[`TMB_BIT_SPLIT] && run && tick_lo && cnt16 == 16'hFFFF
     && !wr_cnt_lo && !wr_cnt_hi)
    |=> (cnt_lo_reg == $past(rld_lo_reg)) && (cnt_hi_reg == $past(rld_hi_reg))
        && ctrl_reg[`TMB_BIT_HI_OVF] && ctrl_reg[`TMB_BIT_LO_OVF])
    else $error("16-bit wrap did not reload or set both flags");

  AST_WIDE_COUNT: assert property (@(posedge mclk) disable iff (reset)
    (!ctrl_reg[`TMB_BIT_SPLIT] && run && tick_lo && cnt_lo_reg == 8'hFF
     && cnt_hi_reg != 8'hFF && !wr_cnt_lo && !wr_cnt_hi)
    |=> (cnt_lo_reg == 8'h00) && (cnt_hi_reg == $past(cnt_hi_reg) + 8'h01))
    else $error("low byte carry did not reach the high byte");

  AST_WIDE_STOP: assert property (@(posedge mclk) disable iff (reset)
    (!ctrl_reg[`TMB_BIT_SPLIT] && !run && !wr_cnt_lo && !wr_cnt_hi)
    |=> $stable(cnt_lo_reg) && $stable(cnt_hi_reg))
    else $error("stopped timer changed its count");

  AST_SPLIT_LOW_FREE: assert property (@(posedge mclk) disable iff (reset)
    (ctrl_reg[`TMB_BIT_SPLIT] && low_byte_fast_clock_select && !wr_cnt_lo
     && cnt_lo_reg < 8'hFE)
    |=> cnt_lo_reg == $past(cnt_lo_reg) + 8'h01)
    else $error("split low byte did not count on the fast clock");

  AST_SPLIT_HIGH_GATE: assert property (@(posedge mclk) disable iff (reset)
    (ctrl_reg[`TMB_BIT_SPLIT] && !run && !wr_cnt_hi) |=> $stable(cnt_hi_reg))
    else $error("split high byte counted while stopped");

  AST_SPLIT_RELOAD: assert property (@(posedge mclk) disable iff (reset)
    (ctrl_reg[`TMB_BIT_SPLIT] && tick_lo && cnt_lo_reg == 8'hFF && !wr_cnt_lo)
    |=> (cnt_lo_reg == $past(rld_lo_reg)) && ctrl_reg[`TMB_BIT_LO_OVF])
    else $error("split low wrap did not reload or flag");

  AST_SPLIT_HIGH_WRAP: assert property (@(posedge mclk) disable iff (reset)
    (ctrl_reg[`TMB_BIT_SPLIT] && run && tick_hi && cnt_hi_reg == 8'hFF && !wr_cnt_hi)
    |=> (cnt_hi_reg == $past(rld_hi_reg)) && ctrl_reg[`TMB_BIT_HI_OVF])
    else $error("split high wrap did not reload or flag");

  AST_FLAG_STICKY: assert property (@(posedge mclk) disable iff (reset)
    (!wr_ctrl && (ctrl_reg[`TMB_BIT_HI_OVF] || ctrl_reg[`TMB_BIT_LO_OVF]))
    |=> (ctrl_reg[`TMB_BIT_HI_OVF] >= $past(ctrl_reg[`TMB_BIT_HI_OVF]))
        && (ctrl_reg[`TMB_BIT_LO_OVF] >= $past(ctrl_reg[`TMB_BIT_LO_OVF])))
    else $error("overflow flag cleared without a write");

  AST_IRQ_HIGH: assert property (@(posedge mclk) disable iff (reset)
    (timer_irq_enable && ctrl_reg[`TMB_BIT_HI_OVF]) |=> irq_request)
    else $error("high overflow raised no interrupt request");

  AST_IRQ_LOW_GATE: assert property (@(posedge mclk) disable iff (reset)
    (!ctrl_reg[`TMB_BIT_HI_OVF] && !(ctrl_reg[`TMB_BIT_LO_IRQ_EN]
     && ctrl_reg[`TMB_BIT_LO_OVF])) |=> !irq_request)
    else $error("interrupt request without an enabled flag");

  AST_IRQ_NO_ENABLE: assert property (@(posedge mclk) disable iff (reset)
    !timer_irq_enable |=> !irq_request)
    else $error("interrupt request while timer interrupt disabled");

  AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (reset)
    wr_ctrl |=> (ctrl_reg[4] == 1'b0) && (ctrl_reg[1] == 1'b0)
                && (ctrl_reg[`TMB_BIT_RUN] == $past(sfr_wdata[`TMB_BIT_RUN])))
    else $error("control write stored a reserved bit or lost run");

  AST_ALT_DIV12: assert property (@(posedge mclk) disable iff (reset)
    (ctrl_reg[`TMB_BIT_SPLIT] && !low_byte_fast_clock_select
     && !ctrl_reg[`TMB_BIT_ALT_CLK] && !ticks.core_tick && !wr_cnt_lo)
    |=> $stable(cnt_lo_reg))
    else $error("low byte counted without a divided tick");

  AST_READ_RELOAD: assert property (@(posedge mclk) disable iff (reset)
    (sfr_rd && sfr_addr == `TMB_ADDR_RLD_HI) |=> sfr_rdata == $past(rld_hi_reg))
    else $error("reload high read returned wrong data");

endmodule // tmb_timer

`default_nettype wire

/* shared/tmb_map.svh */
`ifndef TMB_MAP_SVH
`define TMB_MAP_SVH

// Register addresses on the special function register port
`define TMB_ADDR_CTRL     8'h91
`define TMB_ADDR_RLD_LO   8'h92
`define TMB_ADDR_RLD_HI   8'h93
`define TMB_ADDR_CNT_LO   8'h94
`define TMB_ADDR_CNT_HI   8'h95

// Control register field positions
`define TMB_BIT_HI_OVF    7
`define TMB_BIT_LO_OVF    6
`define TMB_BIT_LO_IRQ_EN 5
`define TMB_BIT_SPLIT     3
`define TMB_BIT_RUN       2
`define TMB_BIT_ALT_CLK   0

// Writable control bits; bits 4 and 1 stay zero
`define TMB_CTRL_WR_MASK  8'hED

// Reset value of every register
`define TMB_RST_BYTE      8'h00

// Prescaler ratios
`define TMB_CORE_DIV      12
`define TMB_EXT_DIV       8

`endif

/* shared/tmb_pkg.sv */
`default_nettype none

package tmb_pkg;

  typedef logic [7:0] tmb_byte_t;

  // Counter arrangement, one-hot
  typedef enum logic [1:0] {
    TMB_MODE_WIDE  = 2'b01,
    TMB_MODE_SPLIT = 2'b10
  } tmb_mode_e;

endpackage

`default_nettype wire

/* shared/tmb_tick_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface tmb_tick_if;
  logic core_tick;
  logic ext_tick;

  modport src (
    output core_tick,
    output ext_tick
  );

  modport snk (
    input core_tick,
    input ext_tick
  );
endinterface

`default_nettype wire

/* rtl/tmb_tick_gen.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tmb_map.svh"

module tmb_tick_gen #(
  parameter int CORE_DIV = `TMB_CORE_DIV,
  parameter int EXT_DIV  = `TMB_EXT_DIV
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // External oscillator, asynchronous
  input  wire logic ext_clk,
  // Count pulses
  tmb_tick_if.src   ticks
);

  localparam int CW = $clog2(CORE_DIV);
  localparam int EW = $clog2(EXT_DIV);

  logic [CW-1:0] pre_reg,  pre_next;
  logic          core_tick_reg, core_tick_next;
  logic          sync1_reg, sync2_reg, sync3_reg;
  logic [EW-1:0] ecnt_reg, ecnt_next;
  logic          ext_tick_reg, ext_tick_next;
  logic          ext_rise;

  // Core clock divided by twelve
  always_comb begin
    core_tick_next = (pre_reg == CW'(CORE_DIV - 1));
    pre_next       = core_tick_next ? '0 : pre_reg + CW'(1);
  end

  // Edge of the synchronised oscillator; first stage is read by the second only
  always_comb begin
    ext_rise      = sync2_reg & ~sync3_reg;
    ext_tick_next = ext_rise && (ecnt_reg == EW'(EXT_DIV - 1));
    ecnt_next     = ext_rise ? ecnt_reg + EW'(1) : ecnt_reg;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pre_reg       <= '0;
      core_tick_reg <= 1'b0;
      sync1_reg     <= 1'b0;
      sync2_reg     <= 1'b0;
      sync3_reg     <= 1'b0;
      ecnt_reg      <= '0;
      ext_tick_reg  <= 1'b0;
    end else begin
      pre_reg       <= pre_next;
      core_tick_reg <= core_tick_next;
      sync1_reg     <= ext_clk;
      sync2_reg     <= sync1_reg;
      sync3_reg     <= sync2_reg;
      ecnt_reg      <= ecnt_next;
      ext_tick_reg  <= ext_tick_next;
    end
  end

  assign ticks.core_tick = core_tick_reg;
  assign ticks.ext_tick  = ext_tick_reg;

  AST_CORE_PERIOD: assert property (@(posedge mclk) disable iff (reset)
    core_tick_reg |-> ##12 core_tick_reg)
    else $error("core tick period is not twelve cycles");

  AST_EXT_SPACING: assert property (@(posedge mclk) disable iff (reset)
    ext_tick_reg |=> !ext_tick_reg [*8])
    else $error("external tick faster than one per eight edges");

endmodule // tmb_tick_gen

`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tmb_map.svh"

module tb;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] lo;
    logic [7:0] hi;
  } tmb_note_s;

  localparam logic [7:0] A_CT = `TMB_ADDR_CTRL;
  localparam logic [7:0] A_RL = `TMB_ADDR_RLD_LO;
  localparam logic [7:0] A_RH = `TMB_ADDR_RLD_HI;
  localparam logic [7:0] A_CL = `TMB_ADDR_CNT_LO;
  localparam logic [7:0] A_CH = `TMB_ADDR_CNT_HI;

  logic        mclk;
  logic        reset;
  logic [7:0]  sfr_addr;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic        hfs;
  logic        lfs;
  logic        ext_clk;
  logic        irq_en;
  logic        irq_request;
  logic [1:0]  rd_pipe;
  logic [15:0] rng;
  tmb_note_s   nt;
  tmb_note_s   notes[$];
  int          n_fail;
  int          num_checks;

  tmb_timer dut_u (
    .mclk                        (mclk),
    .reset                       (reset),
    .sfr_addr                    (sfr_addr),
    .sfr_wr                      (sfr_wr),
    .sfr_rd                      (sfr_rd),
    .sfr_wdata                   (sfr_wdata),
    .sfr_rdata                   (sfr_rdata),
    .high_byte_fast_clock_select (hfs),
    .low_byte_fast_clock_select  (lfs),
    .ext_clk                     (ext_clk),
    .timer_irq_enable            (irq_en),
    .irq_request                 (irq_request)
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  function automatic logic [7:0] rnd();
    rng ^= rng << 7;
    rng ^= rng >> 9;
    rng ^= rng << 8;
    return rng[7:0];
  endfunction

  task automatic chk(input string nm, input logic [7:0] lo, input logic [7:0] hi,
                     input logic [7:0] seen);
    num_checks++;
    if ((^seen === 1'bx) || (seen < lo) || (seen > hi)) begin
      n_fail++;
      $display("[ERR] %s expected %h..%h seen %h", nm, lo, hi, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge mclk);
    sfr_wr    <= 1'b0;
  endtask

  // Note first, so the watcher always finds it waiting
  task automatic rd(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    notes.push_back('{a, lo, hi});
    @(posedge mclk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge mclk);
    sfr_rd   <= 1'b0;
  endtask

  task automatic rd1(input logic [7:0] a, input logic [7:0] v);
    rd(a, v, v);
  endtask

  // Six-cycle oscillator period keeps it slower than the core clock
  task automatic tick(input int n);
    repeat (n * `TMB_EXT_DIV) begin
      repeat (3) @(posedge mclk);
      ext_clk <= 1'b1;
      repeat (3) @(posedge mclk);
      ext_clk <= 1'b0;
    end
    repeat (20) @(posedge mclk);
  endtask

  task automatic irq(input logic e, input logic x);
    @(posedge mclk);
    irq_en <= e;
    repeat (3) @(posedge mclk);
    #1 chk("irq_request", {7'h00, x}, {7'h00, x}, {7'h00, irq_request});
    // Back on the rising edge so later stimulus stays edge aligned
    @(posedge mclk);
  endtask

  task automatic final_report();
    if (notes.size() != 0) begin
      n_fail++;
      $display("[ERR] pending reads expected 0 seen %0d", notes.size());
    end
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if ((n_fail == 0) && (num_checks > 0)) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Read data lands one edge after the read edge
  always @(posedge mclk) rd_pipe <= {rd_pipe[0], sfr_rd};

  always @(negedge mclk) begin
    if (rd_pipe[1] === 1'b1) begin
      if (notes.size() == 0) begin
        n_fail++;
        $display("[ERR] rdata note expected 1 seen 0");
      end else begin
        nt = notes.pop_front();
        chk($sformatf("rdata %h", nt.a), nt.lo, nt.hi, sfr_rdata);
      end
    end
  end

  initial begin
    logic [7:0] r1;
    logic [7:0] r2;
    reset = 1'b1;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    hfs = 1'b0;
    lfs = 1'b0;
    ext_clk = 1'b0;
    irq_en = 1'b0;
    rd_pipe = 2'b00;
    rng = 16'h1899;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    for (int a = 8'h90; a <= 8'h96; a++) rd1(8'(a), 8'h00);
    r1 = rnd();
    r2 = rnd();
    wr(A_RL, r1);
    wr(A_RH, r2);
    wr(A_CL, r2);
    wr(A_CH, r1);
    rd1(A_RL, r1);
    rd1(A_RH, r2);
    rd1(A_CL, r2);
    rd1(A_CH, r1);
    wr(A_CT, 8'hFF);
    rd1(A_CT, 8'hED);
    irq(1'b1, 1'b1);
    irq(1'b0, 1'b0);
    wr(A_CT, 8'h00);
    rd1(A_CT, 8'h00);
    // Word wrap on external ticks
    wr(A_CT, 8'h01);
    wr(A_RL, 8'h34);
    wr(A_RH, 8'h12);
    wr(A_CL, 8'hFE);
    wr(A_CH, 8'hFF);
    wr(A_CT, 8'h05);
    tick(3);
    rd1(A_CL, 8'h35);
    rd1(A_CH, 8'h12);
    rd1(A_CT, 8'hC5);
    irq(1'b1, 1'b1);
    wr(A_CT, 8'h05);
    irq(1'b1, 1'b0);
    // Low wrap alone in the word
    wr(A_CL, 8'hFE);
    wr(A_CH, 8'h10);
    wr(A_CT, 8'h25);
    tick(2);
    rd1(A_CH, 8'h11);
    rd1(A_CT, 8'h65);
    irq(1'b1, 1'b1);
    wr(A_CT, 8'h45);
    irq(1'b1, 1'b0);
    wr(A_CT, 8'h01);
    tick(2);
    rd1(A_CL, 8'h00);
    // Split bytes
    wr(A_RL, 8'hA0);
    wr(A_RH, 8'hB0);
    wr(A_CL, 8'hFF);
    wr(A_CH, 8'hFF);
    wr(A_CT, 8'h09);
    tick(1);
    rd1(A_CL, 8'hA0);
    rd1(A_CH, 8'hFF);
    rd1(A_CT, 8'h49);
    irq(1'b1, 1'b0);
    wr(A_CT, 8'h69);
    irq(1'b1, 1'b1);
    wr(A_CT, 8'h0D);
    tick(1);
    rd1(A_CL, 8'hA1);
    rd1(A_CH, 8'hB0);
    rd1(A_CT, 8'h8D);
    irq(1'b1, 1'b1);
    // Per-byte fast select; exact phase unknown, so a window
    hfs <= 1'b1;
    wr(A_CT, 8'h0D);
    repeat (20) @(posedge mclk);
    wr(A_CT, 8'h09);
    hfs <= 1'b0;
    rd1(A_CL, 8'hA1);
    rd(A_CH, 8'hC0, 8'hCF);
    lfs <= 1'b1;
    repeat (20) @(posedge mclk);
    lfs <= 1'b0;
    rd(A_CL, 8'hB0, 8'hBF);
    // Divide-by-12 source, about ten ticks
    wr(A_CT, 8'h00);
    wr(A_CL, 8'h00);
    wr(A_CH, 8'h00);
    wr(A_CT, 8'h04);
    repeat (118) @(posedge mclk);
    wr(A_CT, 8'h00);
    rd(A_CL, 8'h09, 8'h0B);
    rd1(A_CH, 8'h00);
    // Split low byte on the divided clock; 120 edges hold ten pulses
    wr(A_CL, 8'h00);
    wr(A_CT, 8'h08);
    repeat (118) @(posedge mclk);
    wr(A_CT, 8'h00);
    rd1(A_CL, 8'h0A);
    rd1(A_CH, 8'h00);
    repeat (4) @(posedge mclk);
    // Second reset in mid-run
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rd1(A_RL, 8'h00);
    rd1(A_CL, 8'h00);
    irq(1'b1, 1'b0);
    repeat (4) @(posedge mclk);
    final_report();
  end
endmodule // tb

`default_nettype wire
